/* File: pcie_link_control_register.sv */
// Summary of operation
// - Power management off keeps clock request low
// - Power management on may release clock request
// - Extended synch requests longer FTS and TS2
// - Common clock bit selects reported exit latencies
// - Retrain link bit reads zero, ignores writes
// - Link disable bit reads zero, ignores writes
// - Boundary bit stored; own boundary stays 128
// - Boundary bit zero 64 bytes, one 128
// - Reserved bit 2 reads zero
// - Reserved bits 15 to 9 read zero
// - Power control field gates L0s and L1 entry
// - L0s latency code 011 common, 100 async
module pcie_link_control_register #(
    parameter logic [2:0] L1_LAT_COMMON = link_power_pkg::L1_EXIT_LAT_COMMON_DEF,
    parameter logic [2:0] L1_LAT_ASYNC  = link_power_pkg::L1_EXIT_LAT_ASYNC_DEF
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset,
    input  wire link_power_pkg::cfg_req_t   i_cfg,
    input  wire logic                       i_clkreq_release_want,
    input  wire logic                       i_l0s_entry_want,
    input  wire logic                       i_l1_entry_want,
    output logic [15:0]                     o_cfg_rdata,
    output logic                            o_cfg_rvalid,
    output logic                            o_clkreq_n,
    output logic                            o_extended_synch,
    output link_power_pkg::exit_lat_t       o_exit_lat,
    output logic                            o_l0s_entry_allow,
    output logic                            o_l1_entry_allow,
    output logic                            o_completion_boundary,
    output logic [7:0]                      o_own_boundary_bytes
);

    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [15:0] be_mask;
    logic        hit;
    logic        clkreq_want_meta_r;
    logic        clkreq_want_sync_r;

    assign hit     = i_cfg.addr == link_power_pkg::LINK_POWER_CONTROL_OFFSET;
    assign be_mask = {{8{i_cfg.be[1]}}, {8{i_cfg.be[0]}}};

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        if (i_cfg.wr && hit)
        begin
            ctrl_nxt = (ctrl_r & ~(be_mask & link_power_pkg::LINK_POWER_CONTROL_WMASK))
                     | (i_cfg.wdata & be_mask & link_power_pkg::LINK_POWER_CONTROL_WMASK);
        end
    end

    // Control bits
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            ctrl_r <= link_power_pkg::LINK_POWER_CONTROL_RESET;
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Read path
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_cfg_rdata  <= 16'h0000;
            o_cfg_rvalid <= 1'b0;
        end
        else
        begin
            o_cfg_rvalid <= i_cfg.rd;
            o_cfg_rdata  <= (i_cfg.rd && hit) ?
                            (ctrl_r & link_power_pkg::LINK_POWER_CONTROL_WMASK) : 16'h0000;
        end
    end

    // Clock request pin input synchroniser
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            clkreq_want_meta_r <= 1'b0;
            clkreq_want_sync_r <= 1'b0;
        end
        else
        begin
            clkreq_want_meta_r <= i_clkreq_release_want;
            clkreq_want_sync_r <= clkreq_want_meta_r;
        end
    end

    // Link side controls
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_clkreq_n            <= 1'b0;
            o_extended_synch      <= 1'b0;
            o_exit_lat            <= '{l0s_exit_lat: link_power_pkg::L0S_EXIT_LAT_ASYNC,
                                       l1_exit_lat:  L1_LAT_ASYNC};
            o_l0s_entry_allow     <= 1'b0;
            o_l1_entry_allow      <= 1'b0;
            o_completion_boundary <= 1'b0;
            o_own_boundary_bytes  <= 8'(link_power_pkg::OWN_COMPLETION_BYTES);
        end
        else
        begin
            o_clkreq_n <= ctrl_nxt[link_power_pkg::CLKREQ_PM_ENABLE_BIT]
                        & clkreq_want_sync_r;
            o_extended_synch <= ctrl_nxt[link_power_pkg::EXTENDED_SYNCH_BIT];
            if (ctrl_nxt[link_power_pkg::COMMON_REFCLK_CONFIG_BIT])
            begin
                o_exit_lat <= '{l0s_exit_lat: link_power_pkg::L0S_EXIT_LAT_COMMON,
                                l1_exit_lat:  L1_LAT_COMMON};
            end
            else
            begin
                o_exit_lat <= '{l0s_exit_lat: link_power_pkg::L0S_EXIT_LAT_ASYNC,
                                l1_exit_lat:  L1_LAT_ASYNC};
            end
            o_l0s_entry_allow <= ctrl_nxt[link_power_pkg::ASPM_CONTROL_LSB]
                               & i_l0s_entry_want;
            o_l1_entry_allow  <= ctrl_nxt[link_power_pkg::ASPM_CONTROL_LSB + 1]
                               & i_l1_entry_want;
            o_completion_boundary <= ctrl_nxt[link_power_pkg::COMPLETION_BOUNDARY_BIT];
            o_own_boundary_bytes  <= 8'(link_power_pkg::OWN_COMPLETION_BYTES);
        end
    end

    // Clock request checks
    a_clkreq_held_low: assert property (@(posedge i_clk) disable iff (i_reset)
        !ctrl_r[link_power_pkg::CLKREQ_PM_ENABLE_BIT]
        |-> !o_clkreq_n)
        else $error("clock request released while disabled");

    a_clkreq_release: assert property (@(posedge i_clk) disable iff (i_reset)
        o_clkreq_n
        |-> ctrl_r[link_power_pkg::CLKREQ_PM_ENABLE_BIT])
        else $error("clock request released without enable");

    a_clkreq_follow: assert property (@(posedge i_clk) disable iff (i_reset)
        o_clkreq_n == (ctrl_r[link_power_pkg::CLKREQ_PM_ENABLE_BIT]
                       && $past(clkreq_want_sync_r)))
        else $error("clock request does not follow enable and want");

    // Link exit controls
    a_ext_synch_follow: assert property (@(posedge i_clk) disable iff (i_reset)
        o_extended_synch == ctrl_r[link_power_pkg::EXTENDED_SYNCH_BIT])
        else $error("extended synch output mismatch");

    a_l0s_lat_code: assert property (@(posedge i_clk) disable iff (i_reset)
        o_exit_lat.l0s_exit_lat == (ctrl_r[link_power_pkg::COMMON_REFCLK_CONFIG_BIT]
            ? link_power_pkg::L0S_EXIT_LAT_COMMON : link_power_pkg::L0S_EXIT_LAT_ASYNC))
        else $error("L0s exit latency code wrong");

    a_l1_lat_select: assert property (@(posedge i_clk) disable iff (i_reset)
        o_exit_lat.l1_exit_lat == (ctrl_r[link_power_pkg::COMMON_REFCLK_CONFIG_BIT]
            ? L1_LAT_COMMON : L1_LAT_ASYNC))
        else $error("L1 exit latency not selected by common clock");

    // Configuration access steps
    sequence s_rd_req;
        i_cfg.rd && hit;
    endsequence

    sequence s_rd_miss;
        i_cfg.rd && !hit;
    endsequence

    sequence s_rd_idle;
        !i_cfg.rd;
    endsequence

    sequence s_wr_full;
        i_cfg.wr && hit && (&i_cfg.be);
    endsequence

    sequence s_wr_low;
        i_cfg.wr && hit && i_cfg.be == 2'h1;
    endsequence

    sequence s_wr_high;
        i_cfg.wr && hit && i_cfg.be == 2'h2;
    endsequence

    sequence s_wr_miss;
        i_cfg.wr && !hit;
    endsequence

    sequence s_no_wr;
        !(i_cfg.wr && hit);
    endsequence

    a_ro_bits_clear: assert property (@(posedge i_clk) disable iff (i_reset)
        (ctrl_r & ~link_power_pkg::LINK_POWER_CONTROL_WMASK)
        == 16'h0000)
        else $error("read only bits stored nonzero");

    a_read_ro_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        s_rd_req
        |=> (o_cfg_rdata & ~link_power_pkg::LINK_POWER_CONTROL_WMASK) == 16'h0000)
        else $error("read only bits read nonzero");

    a_read_matches: assert property (@(posedge i_clk) disable iff (i_reset)
        s_rd_req
        |=> o_cfg_rvalid && o_cfg_rdata == $past(ctrl_r))
        else $error("readback differs from stored value");

    a_read_miss_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        s_rd_miss
        |=> o_cfg_rvalid && o_cfg_rdata == 16'h0000)
        else $error("read of other offset not zero");

    a_rdata_idle_zero: assert property (@(posedge i_clk) disable iff (i_reset)
        s_rd_idle
        |=> !o_cfg_rvalid && o_cfg_rdata == 16'h0000)
        else $error("read data shown without read");

    a_write_masked: assert property (@(posedge i_clk) disable iff (i_reset)
        s_wr_full
        |=> ctrl_r == ($past(i_cfg.wdata) & link_power_pkg::LINK_POWER_CONTROL_WMASK))
        else $error("write stored wrong bits");

    a_write_low_byte: assert property (@(posedge i_clk) disable iff (i_reset)
        s_wr_low
        |=> ctrl_r[15:8] == $past(ctrl_r[15:8]) && ctrl_r[7:0] ==
            ($past(i_cfg.wdata[7:0]) & link_power_pkg::LINK_POWER_CONTROL_WMASK[7:0]))
        else $error("low byte write stored wrong bits");

    a_write_high_byte: assert property (@(posedge i_clk) disable iff (i_reset)
        s_wr_high
        |=> ctrl_r[7:0] == $past(ctrl_r[7:0]) && ctrl_r[15:8] ==
            ($past(i_cfg.wdata[15:8]) & link_power_pkg::LINK_POWER_CONTROL_WMASK[15:8]))
        else $error("high byte write stored wrong bits");

    a_write_miss_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        s_wr_miss
        |=> $stable(ctrl_r))
        else $error("write to other offset changed register");

    a_no_write_hold: assert property (@(posedge i_clk) disable iff (i_reset)
        s_no_wr
        |=> $stable(ctrl_r))
        else $error("register changed without write");

    a_reset_clears: assert property (@(posedge i_clk)
        i_reset
        |=> ctrl_r == link_power_pkg::LINK_POWER_CONTROL_RESET && !o_cfg_rvalid)
        else $error("reset did not clear register");

    // Power state entry gating
    a_l0s_gate: assert property (@(posedge i_clk) disable iff (i_reset)
        o_l0s_entry_allow == (ctrl_r[link_power_pkg::ASPM_CONTROL_LSB]
                              && $past(i_l0s_entry_want)))
        else $error("L0s entry allow does not follow field and want");

    a_l1_gate: assert property (@(posedge i_clk) disable iff (i_reset)
        o_l1_entry_allow == (ctrl_r[link_power_pkg::ASPM_CONTROL_LSB + 1]
                             && $past(i_l1_entry_want)))
        else $error("L1 entry allow does not follow field and want");

    a_aspm_gate: assert property (@(posedge i_clk) disable iff (i_reset)
        (o_l0s_entry_allow |-> ctrl_r[link_power_pkg::ASPM_CONTROL_LSB])
        and (o_l1_entry_allow |-> ctrl_r[link_power_pkg::ASPM_CONTROL_LSB + 1]))
        else $error("power state entry allowed while disabled");

    a_aspm_off_mode: assert property (@(posedge i_clk) disable iff (i_reset)
        ctrl_r[link_power_pkg::ASPM_CONTROL_LSB +: 2] == link_power_pkg::ASPM_DISABLED
        |-> !o_l0s_entry_allow && !o_l1_entry_allow)
        else $error("power state entry allowed while field off");

    a_aspm_l0s_mode: assert property (@(posedge i_clk) disable iff (i_reset)
        ctrl_r[link_power_pkg::ASPM_CONTROL_LSB +: 2] == link_power_pkg::ASPM_L0S_ONLY
        |-> !o_l1_entry_allow)
        else $error("L1 entry allowed in L0s only mode");

    a_aspm_l1_mode: assert property (@(posedge i_clk) disable iff (i_reset)
        ctrl_r[link_power_pkg::ASPM_CONTROL_LSB +: 2] == link_power_pkg::ASPM_L1_ONLY
        |-> !o_l0s_entry_allow)
        else $error("L0s entry allowed in L1 only mode");

    a_aspm_both_mode: assert property (@(posedge i_clk) disable iff (i_reset)
        ctrl_r[link_power_pkg::ASPM_CONTROL_LSB +: 2] == link_power_pkg::ASPM_BOTH
        |-> o_l0s_entry_allow == $past(i_l0s_entry_want))
        else $error("L0s entry blocked with both states enabled");

    // Completion boundary
    a_boundary_bit: assert property (@(posedge i_clk) disable iff (i_reset)
        o_completion_boundary
        == ctrl_r[link_power_pkg::COMPLETION_BOUNDARY_BIT])
        else $error("completion boundary output wrong");

    a_own_boundary_fixed: assert property (@(posedge i_clk) disable iff (i_reset)
        o_own_boundary_bytes
        == 8'(link_power_pkg::OWN_COMPLETION_BYTES))
        else $error("own completion boundary not fixed");

endmodule : pcie_link_control_register

/* File: link_power_pkg.sv */
package link_power_pkg;

    localparam logic [7:0]  LINK_POWER_CONTROL_OFFSET = 8'ha0;
    localparam logic [15:0] LINK_POWER_CONTROL_RESET  = 16'h0000;
    localparam logic [15:0] LINK_POWER_CONTROL_WMASK  = 16'h01cb;

    localparam int unsigned ASPM_CONTROL_LSB          = 0;
    localparam int unsigned COMPLETION_BOUNDARY_BIT   = 3;
    localparam int unsigned COMMON_REFCLK_CONFIG_BIT  = 6;
    localparam int unsigned EXTENDED_SYNCH_BIT        = 7;
    localparam int unsigned CLKREQ_PM_ENABLE_BIT      = 8;

    localparam logic [2:0]  L0S_EXIT_LAT_COMMON       = 3'h3;
    localparam logic [2:0]  L0S_EXIT_LAT_ASYNC        = 3'h4;
    localparam logic [2:0]  L1_EXIT_LAT_COMMON_DEF    = 3'h2;
    localparam logic [2:0]  L1_EXIT_LAT_ASYNC_DEF     = 3'h3;
    localparam int unsigned OWN_COMPLETION_BYTES      = 128;

    localparam logic [1:0]  ASPM_DISABLED             = 2'h0;
    localparam logic [1:0]  ASPM_L0S_ONLY             = 2'h1;
    localparam logic [1:0]  ASPM_L1_ONLY              = 2'h2;
    localparam logic [1:0]  ASPM_BOTH                 = 2'h3;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [1:0]  be;
        logic [15:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic [2:0] l0s_exit_lat;
        logic [2:0] l1_exit_lat;
    } exit_lat_t;

endpackage : link_power_pkg

/* File: link_side_model.sv */
module link_side_model (
    input  wire logic i_clk,
    input  wire logic i_want_all,
    output logic      o_clkreq_release_want,
    output logic      o_l0s_entry_want,
    output logic      o_l1_entry_want
);
    timeunit 1ns;
    timeprecision 1ns;
    // Link logic asks for release and entry from one launch edge
    always_ff @(posedge i_clk)
    begin
        o_clkreq_release_want <= i_want_all;
        o_l0s_entry_want      <= i_want_all;
        o_l1_entry_want       <= i_want_all;
    end
endmodule : link_side_model

/* File: pcie_link_control_register_tb.sv */
module pcie_link_control_register_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                     i_clk, i_reset, want_all, rel_w, l0s_w, l1_w, rvalid, clkreq_n;
    logic                     ext_synch, l0s_ok, l1_ok, cb;
    link_power_pkg::cfg_req_t cfg;
    link_power_pkg::exit_lat_t lat;
    logic [15:0]              rdata;
    logic [7:0]               own_bytes;
    int                       err_count, comparisons;
    pcie_link_control_register u_pcie_link_control_register (.i_clk(i_clk), .i_reset(i_reset),
        .i_cfg(cfg), .i_clkreq_release_want(rel_w), .i_l0s_entry_want(l0s_w),
        .i_l1_entry_want(l1_w), .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid),
        .o_clkreq_n(clkreq_n), .o_extended_synch(ext_synch), .o_exit_lat(lat),
        .o_l0s_entry_allow(l0s_ok), .o_l1_entry_allow(l1_ok),
        .o_completion_boundary(cb), .o_own_boundary_bytes(own_bytes));
    link_side_model u_link_side_model (.i_clk(i_clk), .i_want_all(want_all),
        .o_clkreq_release_want(rel_w), .o_l0s_entry_want(l0s_w), .o_l1_entry_want(l1_w));
    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task automatic end_sim;
        $display("checks %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic cfg_wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
        cfg = '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
        @(posedge i_clk);
        #1 cfg = '0;
        @(posedge i_clk);
        #1;
    endtask : cfg_wr
    task automatic cfg_rd(input logic [7:0] a, input logic [15:0] exp);
        int n;
        cfg = '{wr: 1'b0, rd: 1'b1, addr: a, be: 2'h3, wdata: 16'h0000};
        @(posedge i_clk);
        #1 cfg = '0;
        n = 0;
        while (rvalid !== 1'b1 && n < 4)
        begin
            @(posedge i_clk);
            #1 n++;
        end
        if (n == 4)
        begin
            err_count++;
            end_sim();
        end
        chk("rdata", exp, rdata);
        @(posedge i_clk);
        #1;
    endtask : cfg_rd
    initial
    begin
        cfg = '0;
        i_reset = 1'b1;
        want_all = 1'b0;
        repeat (2) @(posedge i_clk);
        #1 i_reset = 1'b0;
        chk("exit_lat", {10'h000, 3'h4, 3'h3}, {10'h000, lat});
        chk("clkreq_n", 16'h0000, {15'h0000, clkreq_n});
        cfg_rd(8'ha0, 16'h0000);
        cfg_wr(8'ha0, 2'h3, 16'hffff);
        chk("ext_synch", 16'h0001, {15'h0000, ext_synch});
        chk("boundary", 16'h0001, {15'h0000, cb});
        chk("own_bytes", 16'h0080, {8'h00, own_bytes});
        chk("exit_lat", {10'h000, 3'h3, 3'h2}, {10'h000, lat});
        cfg_rd(8'ha0, 16'h01cb);
        want_all = 1'b1;
        repeat (5) @(posedge i_clk);
        #1 chk("clkreq_n", 16'h0001, {15'h0000, clkreq_n});
        for (int i = 0; i < 4; i++)
        begin
            cfg_wr(8'ha0, 2'h1, 16'(i));
            chk("aspm", 16'(i), {14'h0000, l1_ok, l0s_ok});
        end
        cfg_wr(8'ha0, 2'h2, 16'h0000);
        chk("clkreq_n", 16'h0000, {15'h0000, clkreq_n});
        cfg_wr(8'ha2, 2'h3, 16'hffff);
        cfg_rd(8'ha2, 16'h0000);
        cfg_rd(8'ha0, 16'h0003);
        i_reset = 1'b1;
        @(posedge i_clk);
        #1 i_reset = 1'b0;
        cfg_rd(8'ha0, 16'h0000);
        end_sim();
    end
endmodule : pcie_link_control_register_tb
